//--- bench/cdap_core_asserts.sv
/* Checker for cdap_core: counter, stack, status flag and option decode relations.
   Bound to the core's ports; one clock and the asynchronous high reset. */
module cdap_core_asserts (
    input wire logic                  i_mclk,          // Clock
    input wire logic                  i_reset,         // Reset
    input wire cdap_pkg::cdap_instr_t i_instr,         // Instruction
    input wire logic                  i_wdog_timeout,  // Timeout pulse
    input wire logic [13:0]           i_cfg_high,      // Option word
    input wire logic [10:0]           o_pc,            // Counter
    input wire logic [7:0]            o_status,        // Status
    input wire logic [1:0]            o_bor_level,     // Brownout code
    input wire logic                  o_bor_detect_en, // Detect usable
    input wire logic                  o_pin_reset_en,  // Pin reset
    input wire logic                  o_wdog_reset_en, // Watchdog reset
    input wire logic [2:0]            o_stack_depth    // Stack use
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    wire logic go = i_instr.exec;
    chk_jump_load: assert property (
        go && i_instr.pc_op inside {cdap_pkg::CDAP_PC_JUMP, cdap_pkg::CDAP_PC_CALL}
        |=> o_pc == $past(i_instr.target)) else $error("jump or call target not loaded");
    chk_irq_vector: assert property (
        go && i_instr.pc_op == cdap_pkg::CDAP_PC_IRQ |=> o_pc == 11'h004
        && o_stack_depth == $past(o_stack_depth) + 3'h1) else $error("interrupt entry wrong");
    chk_pc_step: assert property (
        go && i_instr.pc_op == cdap_pkg::CDAP_PC_NEXT
        && !(i_instr.file_wr && i_instr.file_ofs < 7'h03)
        |=> o_pc == $past(o_pc) + 11'h001) else $error("counter did not step");
    chk_call_push: assert property (
        go && i_instr.pc_op == cdap_pkg::CDAP_PC_CALL
        |=> o_stack_depth == $past(o_stack_depth) + 3'h1) else $error("call did not push");
    chk_ret_pop: assert property (
        go && i_instr.pc_op == cdap_pkg::CDAP_PC_RETURN
        |=> o_stack_depth == $past(o_stack_depth) - 3'h1) else $error("return did not pop");
    chk_timeout_set: assert property (
        i_wdog_timeout |=> o_status[4]) else $error("timeout flag not set");
    chk_timeout_cause: assert property (
        $rose(o_status[4]) |-> $past(i_wdog_timeout)) else $error("timeout flag without cause");
    chk_sleep_flags: assert property (
        go && i_instr.sleep && !i_instr.wdog_kick && !i_wdog_timeout
        |=> o_status[4:3] == 2'b01) else $error("sleep flags wrong");
    chk_kick_clear: assert property (
        go && i_instr.wdog_kick && !i_instr.sleep && !i_wdog_timeout
        |=> o_status[4:3] == 2'b00) else $error("kick did not clear flags");
    chk_option_decode: assert property (
        1'b1 |=> o_pin_reset_en == $past(i_cfg_high[12])
        && o_bor_level == $past(i_cfg_high[11:10])
        && o_bor_detect_en == ($past(i_cfg_high[11:10]) == 2'b00)) else $error("option decode wrong");
    chk_wdog_mode: assert property (
        i_cfg_high[9:8] != 2'b10 |=> o_wdog_reset_en == $past(i_cfg_high[9]))
        else $error("watchdog mode wrong");
endmodule
bind cdap_core cdap_core_asserts chk_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_instr(i_instr),
    .i_wdog_timeout(i_wdog_timeout), .i_cfg_high(i_cfg_high), .o_pc(o_pc), .o_status(o_status),
    .o_bor_level(o_bor_level), .o_bor_detect_en(o_bor_detect_en), .o_pin_reset_en(o_pin_reset_en),
    .o_wdog_reset_en(o_wdog_reset_en), .o_stack_depth(o_stack_depth));

//--- bench/cdap_rom_model.sv
/* Program memory stand-in for the table pointer port of cdap_core.
   Assumes a combinational read of the addressed 14-bit word. */
module cdap_rom_model (
    input  wire logic [10:0] i_addr, // Word address
    output logic      [13:0] o_data  // Word at i_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    // Every address bit reaches the word, so a misplaced pointer bit shows up
    assign o_data = {i_addr[2:0], i_addr} ^ 14'h2A5C;
endmodule

//--- bench/tb.sv
/* Self-checking bench for cdap_core against an integer reference model.
   Assumes the ROM stand-in on the table port and the bound checker. */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam cdap_pkg::cdap_pcop_t NX = cdap_pkg::CDAP_PC_NEXT;
    localparam cdap_pkg::cdap_pcop_t JP = cdap_pkg::CDAP_PC_JUMP;
    localparam cdap_pkg::cdap_pcop_t CL = cdap_pkg::CDAP_PC_CALL;
    localparam cdap_pkg::cdap_pcop_t RT = cdap_pkg::CDAP_PC_RETURN;
    localparam cdap_pkg::cdap_pcop_t IQ = cdap_pkg::CDAP_PC_IRQ;
    localparam cdap_pkg::cdap_alu_t  NON = cdap_pkg::CDAP_ALU_NONE;
    localparam cdap_pkg::cdap_alu_t  ADD = cdap_pkg::CDAP_ALU_ADD;
    localparam cdap_pkg::cdap_alu_t  SUB = cdap_pkg::CDAP_ALU_SUB;
    logic                   i_mclk, i_reset, i_wdog_timeout, i_low_power;
    cdap_pkg::cdap_instr_t  i_instr;
    logic [13:0]            i_rom_data, i_cfg_high, i_cfg_low, tab_q;
    logic [10:0]            o_pc, o_rom_addr;
    cdap_pkg::cdap_result_t o_result;
    logic [7:0]             o_status;
    logic                   o_pin_reset_en, o_bor_detect_en, o_wdog_reset_en, o_lib_lock;
    logic [1:0]             o_bor_level;
    logic [3:0]             o_lib_extent;
    logic [2:0]             o_stack_depth;
    int                     fails, num_checks, tv_cnt, n, m_pc, m_st, m_ptr, m_lat, m_tab, sp;
    int                     mem [512];
    int                     stk [8];
    cdap_core dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_por(i_reset), .i_instr(i_instr),
        .i_wdog_timeout(i_wdog_timeout), .i_low_power(i_low_power), .i_rom_data(i_rom_data),
        .i_cfg_high(i_cfg_high), .i_cfg_low(i_cfg_low), .o_pc(o_pc), .o_rom_addr(o_rom_addr),
        .o_result(o_result), .o_status(o_status), .o_pin_reset_en(o_pin_reset_en),
        .o_bor_level(o_bor_level), .o_bor_detect_en(o_bor_detect_en),
        .o_wdog_reset_en(o_wdog_reset_en), .o_lib_lock(o_lib_lock),
        .o_lib_extent(o_lib_extent), .o_stack_depth(o_stack_depth));
    cdap_rom_model rom_u (.i_addr(o_rom_addr), .o_data(i_rom_data));
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    always @(negedge i_mclk) begin
        if (o_result.table_valid === 1'b1) tv_cnt++;
        if (o_result.table_valid === 1'b1) tab_q = o_result.table_data;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask
    function automatic int ea(input int ofs, input bit ind);
        int a;
        a = ind ? ((m_st >> 7 & 1) << 8 | m_ptr) : ((m_st >> 5 & 3) << 7 | ofs);
        return (a & 127) >= 112 ? a & 127 : a;
    endfunction
    function automatic int rd(input int a);
        case (a & 127)
            2: return m_pc & 255;
            3: return m_st;
            4: return m_ptr;
            10: return m_lat;
            5: if (a >= 384) return m_tab & 255;
        endcase
        return (a & 127) >= 32 ? mem[a] : 0;
    endfunction
    task automatic wr(input int a, input int d);
        case (a & 127)
            2: m_pc = (m_lat & 7) << 8 | d;
            3: m_st = m_st & 24 | d & 231;
            4: m_ptr = d;
            10: m_lat = d;
            5: if (a >= 384) m_tab = m_tab & 'h700 | d;
            6: if (a >= 384) m_tab = (d & 7) << 8 | m_tab & 255;
            default: if ((a & 127) >= 32) mem[a] = d;
        endcase
    endtask
    task automatic idle(input int k);
        i_instr = '0;
        repeat (k) @(negedge i_mclk);
    endtask
    // Driven at a falling edge and held; the caller ends a burst with idle
    task automatic op(input cdap_pkg::cdap_pcop_t pcop, input int ofs, input bit w, input int d,
                      input cdap_pkg::cdap_alu_t alu = NON, input int a = 0, input int b = 0,
                      input int misc = 0);
        cdap_pkg::cdap_instr_t ins;
        int ad, r, c, dc, exp_rd;
        ins = '0;
        ins.exec = 1'b1;
        ins.pc_op = pcop;
        ins.target = 11'(d);
        ins.file_rd = !w;
        ins.file_wr = w;
        ins.file_ofs = 7'(ofs);
        ins.wr_data = 8'(d);
        ins.alu_op = alu;
        ins.alu_a = 8'(a);
        ins.alu_b = 8'(b);
        {ins.flag_c, ins.flag_dc, ins.flag_z} = {3{misc[3]}};
        ins.wdog_kick = misc[0];
        ins.sleep = misc[1];
        ins.table_rd = misc[2];
        i_instr = ins;
        ad = ea(ofs, ofs == 0);
        exp_rd = rd(ad);
        if (pcop == CL || pcop == IQ) stk[sp] = (pcop == CL ? m_pc + 1 : m_pc) & 2047;
        if (pcop == CL || pcop == IQ) sp = (sp + 1) % 8;
        if (pcop == RT) sp = (sp + 7) % 8;
        m_pc = (pcop == JP || pcop == CL ? d : pcop == RT ? stk[sp] : pcop == IQ ? 4 : m_pc + 1);
        m_pc = m_pc & 2047;
        if (w) wr(ad, d & 255);
        r = alu == ADD ? a + b : alu == SUB ? a - b : b;
        c = alu == SUB ? a >= b : r > 255;
        dc = alu == SUB ? (a & 15) >= (b & 15) : (a & 15) + (b & 15) > 15;
        if (misc[3]) m_st = m_st & 248 | (r & 255 ? 0 : 4) | dc << 1 | c;
        if (misc[0]) m_st &= 231;
        if (misc[1]) m_st = m_st & 239 | 8;
        if (i_wdog_timeout) m_st |= 16;
        @(posedge i_mclk);
        @(negedge i_mclk);
        check(o_pc, m_pc, "counter");
        check(o_status, m_st, "status");
        check(o_stack_depth, sp, "stack depth");
        if (!w) check(o_result.rd_data, exp_rd, "read data");
        if (alu != NON) check(o_result.alu_result, r & 255, "alu result");
    endtask
    task automatic do_reset();
        i_reset = 1'b1;
        idle(2);
        check(o_pc, 0, "counter after reset");
        check(o_status, 0, "status after reset");
        i_reset = 1'b0;
        {m_pc, m_st, m_ptr, m_lat, m_tab, sp} = '0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge i_mclk);
        fails++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h8352));
        {i_wdog_timeout, i_low_power, i_cfg_high, i_cfg_low} = '0;
        i_instr = '0;
        do_reset();
        for (int k = 0; k < 32; k++) begin
            i_cfg_high = 14'(k << 8);
            i_low_power = k[4];
            i_cfg_low = 14'($urandom);
            idle(2);
            check(o_pin_reset_en, k[4], "pin reset");
            check({o_bor_level, o_bor_detect_en}, {k[3:2], k[3:2] == 2'b00}, "brownout");
            check(o_wdog_reset_en, k[1] && (k[0] || !k[4]), "watchdog mode");
            check({o_lib_lock, o_lib_extent}, i_cfg_low[13:9], "library lock");
        end
        for (int p = 0; p < 8; p++) begin
            op(NX, 3, 1, p << 5 & 96);
            op(NX, 'h20, p < 4, $urandom & 255);
            op(NX, 'h6F, p < 4, $urandom & 255);
            op(NX, 'h70 + (p < 4 ? p : 7 - p) * 5, p < 4, $urandom & 255);
        end
        op(NX, 4, 1, 'h20);
        op(NX, 0, 0, 0);
        op(NX, 0, 1, $urandom & 255);
        op(NX, 3, 1, 'h80);
        op(NX, 4, 1, 'hA0);
        op(NX, 0, 0, 0);
        op(NX, 4, 1, 'h00);
        op(NX, 0, 1, 'hFF);
        op(NX, 0, 0, 0);
        op(JP, 3, 0, 'h7F3);
        for (int i = 0; i < 8; i++) op(CL, 2, 0, $urandom & 2047);
        for (int i = 0; i < 8; i++) op(RT, 2, 0, 0);
        op(IQ, 3, 0, 0);
        op(RT, 3, 0, 0);
        op(NX, 10, 1, $urandom & 255);
        op(NX, 2, 1, $urandom & 255);
        op(NX, 2, 0, 0);
        op(NX, 3, 1, 'h60);
        op(NX, 5, 1, $urandom & 255);
        op(NX, 6, 1, $urandom & 255);
        op(NX, 5, 0, 0);
        n = tv_cnt;
        op(NX, 3, 0, 0, NON, 0, 0, 4);
        idle(2);
        check(tv_cnt - n, 1, "table strobe");
        check(o_rom_addr, m_tab, "table pointer");
        check(tab_q, ((m_tab & 7) << 11 | m_tab) ^ 'h2A5C, "table word");
        for (int i = 0; i < 12; i++) op(NX, 2, 0, 0, i % 2 ? SUB : ADD, i < 2 ? 0 : $urandom & 255,
                                        i < 2 ? 0 : $urandom & 255, 8);
        op(NX, 2, 0, 0, cdap_pkg::CDAP_ALU_LOGIC, $urandom & 255, $urandom & 255);
        op(NX, 3, 1, 'hFF, ADD, 'h80, 'h80, 8);
        i_wdog_timeout = 1'b1;
        op(NX, 3, 0, 0, NON, 0, 0, 1);
        i_wdog_timeout = 1'b0;
        op(NX, 3, 0, 0, NON, 0, 0, 2);
        op(NX, 3, 0, 0, NON, 0, 0, 1);
        do_reset();
        op(NX, 3, 0, 0);
        idle(1);
        stop_test();
    end
endmodule

//--- verilog/cdap_core.sv
/*
 * Data bank selection, direct and indirect addressing, program counter,
 * return stack, table reads, ALU flags and status register.
 * Assumes the instruction logic issues at most one instruction per exec strobe,
 * keeps return depth within the stack, and that configuration inputs are static.
 */
// Behaviour
// - direct bank from two status bank bits
// - each bank spans 128 byte offsets
// - top sixteen offsets shared across banks
// - indirect port accesses pointer-addressed register
// - self-indirect reads zero, writes store nothing
// - indirect address is bank bit plus pointer
// - eleven-bit counter, low byte readable only
// - reset to zero, interrupt to four
// - counter otherwise increments by one
// - call and jump load eleven-bit target
// - returns reload counter from stack top
// - low byte write loads upper from latch
// - eight-deep eleven-bit last-in-first-out stack
// - table read returns ROM word at pointer
// - ALU flags; subtraction uses inverted borrows
// - status write keeps instruction-affected flags
// - watchdog flag set on timeout, cleared by kick or sleep
// - sleep flag set by sleep, cleared kick
// - indirect bank bit selects bank pairs
// - config bit twelve enables pin reset
// - config bits select brownout level
// - config bits select watchdog reset mode
module cdap_core (
    input  wire logic                  i_mclk,        // System clock
    input  wire logic                  i_reset,       // Any reset, async high
    input  wire logic                  i_por,         // Power-on or brownout reset
    input  wire cdap_pkg::cdap_instr_t i_instr,       // Decoded instruction
    input  wire logic                  i_wdog_timeout,// Watchdog expired pulse
    input  wire logic                  i_low_power,   // Idle or stop mode
    input  wire logic [13:0]           i_rom_data,    // ROM word at o_rom_addr
    input  wire logic [13:0]           i_cfg_high,    // Config word high
    input  wire logic [13:0]           i_cfg_low,     // Config word low
    output logic [10:0]                o_pc,          // Program counter
    output logic [10:0]                o_rom_addr,    // Table pointer to ROM
    output cdap_pkg::cdap_result_t     o_result,      // Read and ALU results
    output logic [7:0]                 o_status,      // Status register
    output logic                       o_pin_reset_en,// Pin acts as reset
    output logic [1:0]                 o_bor_level,   // Brownout level code
    output logic                       o_bor_detect_en,// Detection flag usable
    output logic                       o_wdog_reset_en,// Watchdog may reset
    output logic                       o_lib_lock,    // Library lock on
    output logic [3:0]                 o_lib_extent,  // Library lock extent
    output logic [2:0]                 o_stack_depth  // Entries in use, wraps
);

    // Returns the 9-bit address mapped for a bank and offset
    function automatic logic [8:0] map_addr(input logic [1:0] bank, input logic [6:0] ofs);
        map_addr = (ofs >= cdap_pkg::OFS_SHARED_BASE) ? {2'h0, ofs} : {bank, ofs};
    endfunction

    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [7:0]  pointer_q;
    logic [7:0]  latch_q;
    logic [7:0]  tbl_lo_q;
    logic [7:0]  tbl_hi_q;
    logic [10:0] pc_q;
    logic [10:0] pc_d;
    logic [10:0] stack_q [cdap_pkg::STACK_DEPTH];
    logic [2:0]  sp_q;
    logic [2:0]  depth_q;
    logic [7:0]  ram_q [cdap_pkg::RAM_WORDS];
    cdap_pkg::cdap_result_t result_q;
    logic        pin_rst_q;
    logic [1:0]  bor_q;
    logic        bor_det_q;
    logic        wdog_en_q;
    logic        lock_q;
    logic [3:0]  extent_q;

    wire cdap_pkg::cdap_instr_t ins = i_instr;

    // Address formation
    wire logic [1:0] dir_bank  = {status_q[cdap_pkg::ST_BANK_HI],
                                  status_q[cdap_pkg::ST_BANK_LO]};
    wire logic [8:0] dir_addr  = map_addr(dir_bank, ins.file_ofs);
    wire logic       is_ind    = (ins.file_ofs == cdap_pkg::OFS_INDIRECT_PORT[6:0]);
    wire logic [8:0] ind_raw   = {status_q[cdap_pkg::ST_IND_BANK], pointer_q};
    wire logic [8:0] ind_addr  = map_addr(ind_raw[8:7], ind_raw[6:0]);
    wire logic [8:0] eff_addr  = is_ind ? ind_addr : dir_addr;
    wire logic [6:0] eff_ofs   = eff_addr[6:0];
    wire logic       self_ind  = is_ind && (ind_addr[6:0] == cdap_pkg::OFS_INDIRECT_PORT[6:0]);

    // Register hits (core registers mirrored in every bank, table pointer in bank 3 only)
    wire logic hit_pcl   = (eff_ofs == cdap_pkg::OFS_PC_LOW[6:0]);
    wire logic hit_stat  = (eff_ofs == cdap_pkg::OFS_STATUS[6:0]);
    wire logic hit_ptr   = (eff_ofs == cdap_pkg::OFS_POINTER[6:0]);
    wire logic hit_latch = (eff_ofs == cdap_pkg::OFS_PC_LATCH[6:0]);
    wire logic hit_tlo   = (eff_addr == cdap_pkg::OFS_TABLE_LOW);
    wire logic hit_thi   = (eff_addr == cdap_pkg::OFS_TABLE_HIGH);
    wire logic hit_ram   = (eff_ofs >= cdap_pkg::OFS_RAM_BASE);

    wire logic do_wr     = ins.exec && ins.file_wr && !self_ind;
    wire logic wr_pcl    = do_wr && hit_pcl;
    wire logic wr_stat   = do_wr && hit_stat;

    // Read mux
    wire logic [7:0] rd_mux =
        self_ind  ? 8'h00 :
        hit_pcl   ? pc_q[7:0] :
        hit_stat  ? status_q :
        hit_ptr   ? pointer_q :
        hit_latch ? latch_q :
        hit_tlo   ? tbl_lo_q :
        hit_thi   ? tbl_hi_q :
        hit_ram   ? ram_q[eff_addr] : 8'h00;

    // ALU with nine-bit and five-bit sums; subtraction adds the complement so carries are inverted borrows
    wire logic [7:0] b_op   = (ins.alu_op == cdap_pkg::CDAP_ALU_SUB) ? ~ins.alu_b : ins.alu_b;
    wire logic       cin    = (ins.alu_op == cdap_pkg::CDAP_ALU_SUB);
    wire logic [8:0] sum    = {1'b0, ins.alu_a} + {1'b0, b_op} + {8'h00, cin};
    wire logic [4:0] nib    = {1'b0, ins.alu_a[3:0]} + {1'b0, b_op[3:0]} + {4'h0, cin};
    wire logic       arith  = (ins.alu_op == cdap_pkg::CDAP_ALU_ADD) ||
                              (ins.alu_op == cdap_pkg::CDAP_ALU_SUB);
    wire logic [7:0] alu_y  = arith ? sum[7:0] : ins.alu_b;

    // Status next value
    always_comb begin
        status_d = status_q;
        if (wr_stat) begin
            status_d[7:5] = ins.wr_data[7:5];
            status_d[2:0] = ins.wr_data[2:0];
            if (ins.flag_c)  status_d[cdap_pkg::ST_CARRY]  = status_q[cdap_pkg::ST_CARRY];
            if (ins.flag_dc) status_d[cdap_pkg::ST_DCARRY] = status_q[cdap_pkg::ST_DCARRY];
            if (ins.flag_z)  status_d[cdap_pkg::ST_ZERO]   = status_q[cdap_pkg::ST_ZERO];
        end
        if (ins.exec && ins.flag_c && arith) begin
            status_d[cdap_pkg::ST_CARRY] = sum[8];
        end
        if (ins.exec && ins.flag_dc && arith) begin
            status_d[cdap_pkg::ST_DCARRY] = nib[4];
        end
        if (ins.exec && ins.flag_z && (ins.alu_op != cdap_pkg::CDAP_ALU_NONE)) begin
            status_d[cdap_pkg::ST_ZERO] = (alu_y == 8'h00);
        end
        if (ins.exec && (ins.wdog_kick || ins.sleep)) begin
            status_d[cdap_pkg::ST_WDOG] = 1'b0;
        end
        if (ins.exec && ins.wdog_kick) begin
            status_d[cdap_pkg::ST_SLEEP] = 1'b0;
        end
        if (ins.exec && ins.sleep) begin
            status_d[cdap_pkg::ST_SLEEP] = 1'b1;
        end
        // Timeout wins over a kick in the same cycle so the event is kept
        if (i_wdog_timeout) begin
            status_d[cdap_pkg::ST_WDOG] = 1'b1;
        end
    end

    // Program counter next value
    wire logic [2:0] sp_top = sp_q - 3'h1;
    always_comb begin
        pc_d = pc_q;
        if (ins.exec) begin
            unique case (ins.pc_op)
                cdap_pkg::CDAP_PC_NEXT:   pc_d = pc_q + 11'h001;
                cdap_pkg::CDAP_PC_JUMP:   pc_d = ins.target;
                cdap_pkg::CDAP_PC_CALL:   pc_d = ins.target;
                cdap_pkg::CDAP_PC_RETURN: pc_d = stack_q[sp_top];
                cdap_pkg::CDAP_PC_IRQ:    pc_d = cdap_pkg::IRQ_VECTOR;
                default:                  pc_d = pc_q + 11'h001;
            endcase
            if (wr_pcl) begin
                pc_d = {latch_q[2:0], ins.wr_data};
            end
        end
    end

    wire logic push = ins.exec && ((ins.pc_op == cdap_pkg::CDAP_PC_CALL) ||
                                   (ins.pc_op == cdap_pkg::CDAP_PC_IRQ));
    wire logic pop  = ins.exec && (ins.pc_op == cdap_pkg::CDAP_PC_RETURN);
    // Return address: the next instruction after a call, the interrupted one on entry
    wire logic [10:0] push_val = (ins.pc_op == cdap_pkg::CDAP_PC_CALL) ? pc_q + 11'h001 : pc_q;

    // Status, program counter and stack pointer registers
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            status_q <= cdap_pkg::STATUS_RESET;
            pc_q     <= cdap_pkg::RESET_VECTOR;
            sp_q     <= 3'h0;
            depth_q  <= 3'h0;
        end else begin
            status_q <= status_d;
            pc_q     <= pc_d;
            sp_q     <= push ? sp_q + 3'h1 : (pop ? sp_top : sp_q);
            depth_q  <= push ? depth_q + 3'h1 : (pop ? depth_q - 3'h1 : depth_q);
        end
    end

    // Every reset clears the watchdog and sleep flags; keeping them over pin and watchdog
    // resets would need a reset tree of their own, fed from i_por

    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pointer_q <= 8'h00;
            latch_q   <= 8'h00;
            tbl_lo_q  <= 8'h00;
            tbl_hi_q  <= 8'h00;
        end else begin
            if (do_wr && hit_ptr)   pointer_q <= ins.wr_data;
            if (do_wr && hit_latch) latch_q   <= ins.wr_data;
            if (do_wr && hit_tlo)   tbl_lo_q  <= ins.wr_data;
            if (do_wr && hit_thi)   tbl_hi_q  <= ins.wr_data;
        end
    end

    // Stack storage and data RAM have no reset, like the real arrays
    always_ff @(posedge i_mclk) begin
        if (push) stack_q[sp_q] <= push_val;
        if (do_wr && hit_ram) ram_q[eff_addr] <= ins.wr_data;
    end

    // Results and table read
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            result_q <= '0;
        end else begin
            result_q.rd_data     <= rd_mux;
            result_q.alu_result  <= alu_y;
            result_q.table_valid <= ins.exec && ins.table_rd;
            if (ins.exec && ins.table_rd) result_q.table_data <= i_rom_data;
        end
    end

    // Static configuration decode, registered for clean outputs
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pin_rst_q <= 1'b0;
            bor_q     <= 2'h0;
            bor_det_q <= 1'b0;
            wdog_en_q <= 1'b0;
            lock_q    <= 1'b0;
            extent_q  <= 4'h0;
        end else begin
            pin_rst_q <= i_cfg_high[cdap_pkg::CFG_PIN_RESET];
            bor_q     <= i_cfg_high[cdap_pkg::CFG_BOR_HI:cdap_pkg::CFG_BOR_LO];
            bor_det_q <= (i_cfg_high[cdap_pkg::CFG_BOR_HI:cdap_pkg::CFG_BOR_LO]
                          == cdap_pkg::BOR_2V3_DETECT);
            wdog_en_q <= i_cfg_high[cdap_pkg::CFG_WDOG_HI] &&
                         (i_cfg_high[cdap_pkg::CFG_WDOG_LO] || !i_low_power);
            lock_q    <= i_cfg_low[cdap_pkg::CFG_LIB_LOCK];
            extent_q  <= i_cfg_low[cdap_pkg::CFG_LIB_EXT_HI:cdap_pkg::CFG_LIB_EXT_LO];
        end
    end

    // Unused power reset: the flags are cleared by i_reset, which covers it
    wire logic unused_por = i_por;

    assign o_pc            = pc_q;
    assign o_rom_addr      = {tbl_hi_q[2:0], tbl_lo_q};
    assign o_result        = result_q;
    assign o_status        = status_q;
    assign o_pin_reset_en  = pin_rst_q;
    assign o_bor_level     = bor_q;
    assign o_bor_detect_en = bor_det_q;
    assign o_wdog_reset_en = wdog_en_q;
    assign o_lib_lock      = lock_q;
    assign o_lib_extent    = extent_q;
    assign o_stack_depth   = depth_q;

endmodule

//--- verilog/cdap_pkg.sv
/*
 * Shared constants and carrier types for the CPU data addressing, program counter
 * and return stack block. Assumes one system clock and an instruction decoder
 * that presents one decoded instruction per execution strobe.
 */
package cdap_pkg;

    // Register offsets within a bank (table pointer sits in bank 3 only)
    localparam logic [8:0] OFS_INDIRECT_PORT = 9'h000;
    localparam logic [8:0] OFS_PC_LOW        = 9'h002;
    localparam logic [8:0] OFS_STATUS        = 9'h003;
    localparam logic [8:0] OFS_POINTER       = 9'h004;
    localparam logic [8:0] OFS_PC_LATCH      = 9'h00A;
    localparam logic [8:0] OFS_TABLE_LOW     = 9'h185;
    localparam logic [8:0] OFS_TABLE_HIGH    = 9'h186;

    // Bank geometry
    localparam logic [6:0] OFS_SHARED_BASE   = 7'h70;
    localparam logic [6:0] OFS_RAM_BASE      = 7'h20;
    localparam int         RAM_WORDS         = 512;

    // Status field positions
    localparam int ST_CARRY     = 0;
    localparam int ST_DCARRY    = 1;
    localparam int ST_ZERO      = 2;
    localparam int ST_SLEEP     = 3;
    localparam int ST_WDOG      = 4;
    localparam int ST_BANK_LO   = 5;
    localparam int ST_BANK_HI   = 6;
    localparam int ST_IND_BANK  = 7;

    localparam logic [7:0]  STATUS_RESET   = 8'h00;
    localparam logic [10:0] RESET_VECTOR   = 11'h000;
    localparam logic [10:0] IRQ_VECTOR     = 11'h004;
    localparam int          STACK_DEPTH    = 8;

    // Configuration word high fields, then library lock fields of the low word
    localparam int CFG_PIN_RESET  = 12;
    localparam int CFG_BOR_HI     = 11;
    localparam int CFG_BOR_LO     = 10;
    localparam int CFG_WDOG_HI    = 9;
    localparam int CFG_WDOG_LO    = 8;
    localparam int CFG_LIB_LOCK   = 13;
    localparam int CFG_LIB_EXT_HI = 12;
    localparam int CFG_LIB_EXT_LO = 9;

    localparam logic [1:0] BOR_2V3_DETECT = 2'h0;

    typedef enum logic [1:0] {
        CDAP_ALU_NONE,
        CDAP_ALU_ADD,
        CDAP_ALU_SUB,
        CDAP_ALU_LOGIC
    } cdap_alu_t;

    typedef enum logic [2:0] {
        CDAP_PC_NEXT,
        CDAP_PC_JUMP,
        CDAP_PC_CALL,
        CDAP_PC_RETURN,
        CDAP_PC_IRQ
    } cdap_pcop_t;

    // One decoded instruction from the execution logic
    typedef struct packed {
        logic       exec;      // Instruction completes this cycle
        cdap_pcop_t pc_op;
        logic [10:0] target;   // Jump or call target from instruction word
        logic       file_rd;
        logic       file_wr;
        logic [6:0] file_ofs;  // Direct offset within bank
        logic [7:0] wr_data;
        cdap_alu_t  alu_op;
        logic [7:0] alu_a;
        logic [7:0] alu_b;
        logic       flag_c;    // Instruction affects carry
        logic       flag_dc;
        logic       flag_z;
        logic       table_rd;
        logic       wdog_kick;
        logic       sleep;
    } cdap_instr_t;

    typedef struct packed {
        logic [7:0]  rd_data;
        logic [7:0]  alu_result;
        logic [13:0] table_data;
        logic        table_valid;
    } cdap_result_t;

endpackage
